// [decoder_defines.vh]
// Constants of the instruction decoder and its return stack.
`ifndef DECODER_DEFINES_VH
`define DECODER_DEFINES_VH

// Depth of the return stack.
`define STACK_DEPTH 8

// Instruction classes in the two top bits.
`define CLASS_BYTE 2'h0
`define CLASS_BIT 2'h1
`define CLASS_JUMP 2'h2
`define CLASS_LIT 2'h3

// Byte-oriented operation codes.
`define OP_MOVE_OUT 4'h0
`define OP_CLEAR 4'h1
`define OP_SUB 4'h2
`define OP_DEC 4'h3
`define OP_OR 4'h4
`define OP_AND 4'h5
`define OP_XOR 4'h6
`define OP_ADD 4'h7
`define OP_MOVE 4'h8
`define OP_COMP 4'h9
`define OP_INC 4'ha
`define OP_DEC_SKIP 4'hb
`define OP_ROT_RIGHT 4'hc
`define OP_ROT_LEFT 4'hd
`define OP_SWAP 4'he
`define OP_INC_SKIP 4'hf

// Bit-oriented operations.
`define BIT_CLEAR 2'h0
`define BIT_SET 2'h1
`define BIT_SKIP_CLEAR 2'h2
`define BIT_SKIP_SET 2'h3

// Fixed control words of the byte class.
`define WORD_RETURN 14'h0008
`define WORD_INT_RETURN 14'h0009
`define WORD_SLEEP 14'h0063
`define WORD_WDT_CLEAR 14'h0064

// File addresses with side effects.
`define TIMER_ADDR 7'h01
`define PORT_ADDR 7'h06

// Register bus offsets (byte addresses).
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ACC 8'h08
`define REG_PC 8'h0c

// Reset values.
`define RST_PC 13'h0000
`define RST_ACC 8'h00

`endif

// [return_stack.v]
// Eight-level circular return stack with a registered top-of-stack output.
`default_nettype none
`include "decoder_defines.vh"

module return_stack (
  // Clock and reset.
  input  wire        clk_i,
  input  wire        rst_i,
  // Push and pop strobes with the pushed address.
  input  wire        push_i,
  input  wire        pop_i,
  input  wire [12:0] push_data_i,
  // Address on top of the stack.
  output reg  [12:0] top_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage.
  reg [12:0] mem_r [0:`STACK_DEPTH-1];  // Saved return addresses.
  reg [2:0]  ptr_r;                      // Next free slot; wraps on overflow.

  ////////////////////////////////////////////////////////////////////////////
  // Memory array: only written, so no reset is needed.
  always @(posedge clk_i) begin
    if (push_i) begin
      mem_r[ptr_r] <= push_data_i;
    end
  end

  // Pointer and registered top, which mirrors mem_r[ptr_r - 1].
  always @(posedge clk_i) begin
    if (rst_i) begin
      ptr_r <= 3'h0;
      top_o <= `RST_PC;
    end else if (push_i) begin
      // A push puts the new address on top at once.
      ptr_r <= ptr_r + 3'h1;
      top_o <= push_data_i;
    end else if (pop_i) begin
      // A pop exposes the entry below the old top.
      ptr_r <= ptr_r - 3'h1;
      top_o <= mem_r[ptr_r - 3'h2];
    end
  end

endmodule

`default_nettype wire

// [fourteen_bit_instruction_decoder.v]
// Executes 14-bit instruction words; Wishbone status view.
//
// Operation
// RULE1 - Class 00: opcode, destination bit, file address.
// RULE2 - Destination 0 to accumulator, 1 to file.
// RULE3 - Opcode 0100 ORs, 0101 ANDs; zero flag only.
// RULE4 - Opcode 0110 exclusive-ORs; zero flag only.
// RULE5 - Add and subtract update carry, digit, zero.
// RULE6 - Opcode 1101 rotates left through carry.
// RULE7 - Opcode 1100 rotates right through carry.
// RULE8 - Opcode 1011 decrements, skips on zero.
// RULE9 - Opcode 1111 increments, skips on zero.
// RULE10 - Class 01: clear, set, skip-if-clear bit.
// RULE11 - Bit operation 11 skips when bit set.
// RULE12 - Literal 1000 ORs, 1001 ANDs; zero flag.
// RULE13 - Literal 1010 exclusive-ORs; zero flag only.
// RULE14 - 01xx loads and returns; 00xx only loads.
// RULE15 - Standby and watchdog words update timeout, powerdown.
// RULE16 - Port operands come from the pins.
// RULE17 - Timer write clears prescaler when assigned.
// RULE18 - Taken branch or skip adds a dead cycle.
// RULE19 - Class 10 jumps: call pushes, branch not.
// RULE20 - Return words pop; interrupt return sets enable.
//
// The register offsets and the Wishbone register port are this design's own decisions.
`default_nettype none
`include "decoder_defines.vh"

module fourteen_bit_instruction_decoder (
  // Clock and reset.
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave.
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Program memory.
  output reg  [12:0] pc_o,
  input  wire [13:0] instr_i,
  // File register port, written at the clock edge.
  output wire [6:0]  file_addr_o,
  input  wire [7:0]  file_rdata_i,
  output reg         file_we_o,
  output reg  [7:0]  file_wdata_o,
  // Port pins and timer prescaler.
  input  wire [7:0]  port_pins_i,
  input  wire        prescaler_to_timer_i,
  output reg         prescaler_clear_o,
  // Power and interrupt state.
  input  wire        wake_i,
  output reg         sleep_o,
  output reg         wdt_clear_o,
  output reg         gie_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers.

  // Returns {digit carry, carry, sum} of a + b + cin.
  function [9:0] alu_add;
    input [7:0] a;
    input [7:0] b;
    input       cin;
    reg   [4:0] lo;
    reg   [8:0] full;
    begin
      lo      = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      full    = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      alu_add = {lo[4], full};
    end
  endfunction

  // True when a byte is zero.
  function is_zero;
    input [7:0] v;
    begin
      is_zero = (v == 8'h00);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.
  reg [7:0]  acc_r;          // Working accumulator.
  reg        carry_r;        // Carry flag.
  reg        digit_r;        // Digit carry flag.
  reg        zero_r;         // Zero flag.
  reg        timeout_r;      // Timeout flag, set at reset.
  reg        powerdown_r;    // Powerdown flag, set at reset.
  reg        flush_r;        // Current cycle is the dead second cycle.
  reg        skip_r;         // Dead cycle also steps past a word.
  reg        run_r;          // Software run enable.
  reg [7:0]  pin_meta_r;     // First pin synchroniser stage.
  reg [7:0]  pin_sync_r;     // Second pin synchroniser stage.

  // Next values.
  reg [12:0] pc_nxt;
  reg [7:0]  acc_nxt;
  reg        carry_nxt;
  reg        digit_nxt;
  reg        zero_nxt;
  reg        timeout_nxt;
  reg        powerdown_nxt;
  reg        flush_nxt;
  reg        skip_nxt;
  reg        sleep_nxt;
  reg        gie_set;        // Interrupt return asks to set enable.
  reg        wdt_nxt;
  reg        push;
  reg        pop;
  reg [7:0]  res;            // Result of the byte operation.
  reg [9:0]  sum;            // Adder output with carries.
  reg [7:0]  mask;           // One-hot bit mask.

  wire [12:0] stack_top;     // Registered return address.
  wire [3:0]  opcode   = instr_i[11:8];
  wire        dest     = instr_i[7];
  wire [7:0]  literal  = instr_i[7:0];
  wire        executing = run_r & ~sleep_o & ~flush_r;
  wire        bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        bus_wr   = bus_req & wb_we_i & wb_sel_i[0];

  // Port reads see pin levels, not the output latch.
  wire [7:0]  operand  = (file_addr_o == `PORT_ADDR) ? pin_sync_r  // RULE16
                                                     : file_rdata_i;

  assign file_addr_o = instr_i[6:0];  // RULE1

  ////////////////////////////////////////////////////////////////////////////
  // Return stack.
  return_stack u_stack (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .push_i      (push),
    .pop_i       (pop),
    .push_data_i (pc_o + 13'h0001),
    .top_o       (stack_top)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode and execute one word per cycle.
  always @* begin
    pc_nxt        = pc_o;
    acc_nxt       = acc_r;
    carry_nxt     = carry_r;
    digit_nxt     = digit_r;
    zero_nxt      = zero_r;
    timeout_nxt   = timeout_r;
    powerdown_nxt = powerdown_r;
    flush_nxt     = 1'b0;
    skip_nxt      = 1'b0;
    sleep_nxt     = sleep_o & ~wake_i;
    gie_set       = 1'b0;
    wdt_nxt       = 1'b0;
    push          = 1'b0;
    pop           = 1'b0;
    file_we_o     = 1'b0;
    file_wdata_o  = 8'h00;
    res           = 8'h00;
    sum           = 10'h000;
    mask          = 8'h01 << instr_i[9:7];
    if (flush_r) begin
      // Dead cycle: a skip steps past the fetched word.
      pc_nxt = pc_o + {12'h000, skip_r};  // RULE18
    end else if (executing) begin
      pc_nxt = pc_o + 13'h0001;
      case (instr_i[13:12])
        `CLASS_BYTE: begin
          case (opcode)
            `OP_MOVE_OUT: begin
              if (dest) begin
                // Accumulator copied out to the file.
                file_we_o    = 1'b1;
                file_wdata_o = acc_r;
              end else if (instr_i == `WORD_RETURN ||
                           instr_i == `WORD_INT_RETURN) begin
                pop       = 1'b1;  // RULE20
                pc_nxt    = stack_top;
                flush_nxt = 1'b1;
                gie_set   = (instr_i == `WORD_INT_RETURN);  // RULE20
              end else if (instr_i == `WORD_SLEEP) begin
                sleep_nxt     = 1'b1;  // RULE15
                powerdown_nxt = 1'b0;
                timeout_nxt   = 1'b1;
                wdt_nxt       = 1'b1;
              end else if (instr_i == `WORD_WDT_CLEAR) begin
                wdt_nxt       = 1'b1;  // RULE15
                powerdown_nxt = 1'b1;
                timeout_nxt   = 1'b1;
              end
            end
            default: begin
              // Byte result from operand and accumulator.
              case (opcode)
                `OP_CLEAR: begin
                  res      = 8'h00;
                  zero_nxt = 1'b1;
                end
                `OP_SUB: begin
                  sum       = alu_add(operand, ~acc_r, 1'b1);  // RULE5
                  res       = sum[7:0];
                  carry_nxt = sum[8];
                  digit_nxt = sum[9];
                  zero_nxt  = is_zero(res);
                end
                `OP_ADD: begin
                  sum       = alu_add(operand, acc_r, 1'b0);  // RULE5
                  res       = sum[7:0];
                  carry_nxt = sum[8];
                  digit_nxt = sum[9];
                  zero_nxt  = is_zero(res);
                end
                `OP_OR: begin
                  res      = acc_r | operand;  // RULE3
                  zero_nxt = is_zero(res);
                end
                `OP_AND: begin
                  res      = acc_r & operand;  // RULE3
                  zero_nxt = is_zero(res);
                end
                `OP_XOR: begin
                  res      = acc_r ^ operand;  // RULE4
                  zero_nxt = is_zero(res);
                end
                `OP_DEC: begin
                  res      = operand - 8'h01;
                  zero_nxt = is_zero(res);
                end
                `OP_INC: begin
                  res      = operand + 8'h01;
                  zero_nxt = is_zero(res);
                end
                `OP_MOVE: begin
                  res      = operand;
                  zero_nxt = is_zero(res);
                end
                `OP_COMP: begin
                  res      = ~operand;
                  zero_nxt = is_zero(res);
                end
                `OP_DEC_SKIP: begin
                  res = operand - 8'h01;  // RULE8
                  if (is_zero(res)) begin
                    flush_nxt = 1'b1;  // RULE8
                    skip_nxt  = 1'b1;
                  end
                end
                `OP_INC_SKIP: begin
                  res = operand + 8'h01;  // RULE9
                  if (is_zero(res)) begin
                    flush_nxt = 1'b1;  // RULE9
                    skip_nxt  = 1'b1;
                  end
                end
                `OP_ROT_RIGHT: begin
                  res       = {carry_r, operand[7:1]};  // RULE7
                  carry_nxt = operand[0];
                end
                `OP_ROT_LEFT: begin
                  res       = {operand[6:0], carry_r};  // RULE6
                  carry_nxt = operand[7];
                end
                `OP_SWAP: begin
                  res = {operand[3:0], operand[7:4]};
                end
                default: begin
                  res = operand;
                end
              endcase
              // Destination select.
              if (dest) begin
                file_we_o    = 1'b1;  // RULE2
                file_wdata_o = res;
              end else begin
                acc_nxt = res;  // RULE2
              end
            end
          endcase
        end
        `CLASS_BIT: begin
          case (instr_i[11:10])
            `BIT_CLEAR: begin
              file_we_o    = 1'b1;  // RULE10
              file_wdata_o = operand & ~mask;
            end
            `BIT_SET: begin
              file_we_o    = 1'b1;  // RULE10
              file_wdata_o = operand | mask;
            end
            `BIT_SKIP_CLEAR: begin
              if ((operand & mask) == 8'h00) begin
                flush_nxt = 1'b1;  // RULE10
                skip_nxt  = 1'b1;
              end
            end
            default: begin
              if ((operand & mask) != 8'h00) begin
                flush_nxt = 1'b1;  // RULE11
                skip_nxt  = 1'b1;
              end
            end
          endcase
        end
        `CLASS_JUMP: begin
          // Call pushes pc + 1; both jumps take two cycles.
          push      = ~instr_i[11];  // RULE19
          pc_nxt    = {2'b00, instr_i[10:0]};
          flush_nxt = 1'b1;  // RULE18
        end
        default: begin
          case (opcode[3:2])
            2'h0: begin
              acc_nxt = literal;  // RULE14
            end
            2'h1: begin
              acc_nxt   = literal;  // RULE14
              pop       = 1'b1;
              pc_nxt    = stack_top;
              flush_nxt = 1'b1;
            end
            2'h2: begin
              case (opcode[1:0])
                2'h0: acc_nxt = acc_r | literal;  // RULE12
                2'h1: acc_nxt = acc_r & literal;  // RULE12
                2'h2: acc_nxt = acc_r ^ literal;  // RULE13
                default: acc_nxt = acc_r;
              endcase
              if (opcode[1:0] != 2'h3) begin
                zero_nxt = is_zero(acc_nxt);
              end
            end
            default: begin
              // 110x subtracts accumulator from literal, 111x adds.
              if (opcode[1]) begin
                sum = alu_add(literal, acc_r, 1'b0);  // RULE5
              end else begin
                sum = alu_add(literal, ~acc_r, 1'b1);  // RULE5
              end
              acc_nxt   = sum[7:0];
              carry_nxt = sum[8];
              digit_nxt = sum[9];
              zero_nxt  = is_zero(sum[7:0]);
            end
          endcase
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; only the second stage feeds logic.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_r <= 8'h00;
      pin_sync_r <= 8'h00;
    end else begin
      pin_meta_r <= port_pins_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core state update.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pc_o              <= `RST_PC;
      acc_r             <= `RST_ACC;
      carry_r           <= 1'b0;
      digit_r           <= 1'b0;
      zero_r            <= 1'b0;
      timeout_r         <= 1'b1;
      powerdown_r       <= 1'b1;
      flush_r           <= 1'b0;
      skip_r            <= 1'b0;
      sleep_o           <= 1'b0;
      wdt_clear_o       <= 1'b0;
      prescaler_clear_o <= 1'b0;
    end else begin
      pc_o        <= pc_nxt;
      acc_r       <= acc_nxt;
      carry_r     <= carry_nxt;
      digit_r     <= digit_nxt;
      zero_r      <= zero_nxt;
      timeout_r   <= timeout_nxt;
      powerdown_r <= powerdown_nxt;
      flush_r     <= flush_nxt;
      skip_r      <= skip_nxt;
      sleep_o     <= sleep_nxt;
      wdt_clear_o <= wdt_nxt;
      // Timer write while it owns the prescaler.
      prescaler_clear_o <= file_we_o & prescaler_to_timer_i &  // RULE17
                           (file_addr_o == `TIMER_ADDR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request, writes at that edge.
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      run_r    <= 1'b1;
      gie_o    <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_wr && wb_adr_i == `REG_CTRL) begin
        run_r <= wb_dat_i[0];
      end
      // Interrupt return wins over a same-cycle software clear.
      if (gie_set) begin
        gie_o <= 1'b1;  // RULE20
      end else if (bus_wr && wb_adr_i == `REG_CTRL) begin
        gie_o <= wb_dat_i[1];
      end
      if (bus_req) begin
        case (wb_adr_i)
          `REG_CTRL:   wb_dat_o <= {30'h00000000, gie_o, run_r};
          `REG_STATUS: wb_dat_o <= {25'h0000000, gie_o, sleep_o,
                                    timeout_r, powerdown_r,
                                    zero_r, digit_r, carry_r};
          `REG_ACC:    wb_dat_o <= {24'h000000, acc_r};
          `REG_PC:     wb_dat_o <= {19'h00000, pc_o};
          default:     wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// [decoder_checker.sv]
// Port-level assertions for the instruction decoder.
`default_nettype none
`include "decoder_defines.vh"
module decoder_checker (
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus handshake.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic        wb_ack_o,
  // Program and file ports.
  input wire logic [12:0] pc_o,
  input wire logic [13:0] instr_i,
  input wire logic [6:0]  file_addr_o,
  input wire logic [7:0]  file_rdata_i,
  input wire logic        file_we_o,
  input wire logic [7:0]  file_wdata_o,
  // Timer, power and interrupt state.
  input wire logic        prescaler_to_timer_i,
  input wire logic        prescaler_clear_o,
  input wire logic        wake_i,
  input wire logic        sleep_o,
  input wire logic        wdt_clear_o,
  input wire logic        gie_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  // A request is acked at the next edge, for one cycle.
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  property p_ack; s_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus ack timing wrong");
  // A jump taken is followed by a dead cycle.
  sequence s_jump; instr_i[13:12] == 2'b10 ##1 pc_o == {2'b00, $past(instr_i[10:0])}; endsequence
  property p_jump; s_jump |=> $stable(pc_o); endproperty
  a_jump: assert property (p_jump) else $error("no dead cycle after jump");
  property p_dest; file_we_o |-> !(instr_i[13:12] == 2'b00 && instr_i[11:8] > 4'h1 && !instr_i[7]);
  endproperty
  a_dest: assert property (p_dest) else $error("file write with dest 0");
  property p_bit; file_we_o && instr_i[13:11] == 3'b010 && file_addr_o != `PORT_ADDR |->
    file_wdata_o[instr_i[9:7]] == instr_i[10] &&
    ((file_wdata_o ^ file_rdata_i) & ~(8'h01 << instr_i[9:7])) == 8'h00; endproperty
  a_bit: assert property (p_bit) else $error("bit set or clear wrong");
  property p_presc; file_we_o && file_addr_o == `TIMER_ADDR && prescaler_to_timer_i |=>
    prescaler_clear_o; endproperty
  a_presc: assert property (p_presc) else $error("prescaler not cleared");
  property p_presc_cause; prescaler_clear_o |->
    $past(file_we_o && file_addr_o == `TIMER_ADDR && prescaler_to_timer_i); endproperty
  a_presc_cause: assert property (p_presc_cause) else $error("stray prescaler clear");
  property p_sleep; $rose(sleep_o) |-> wdt_clear_o && $past(instr_i) == `WORD_SLEEP; endproperty
  a_sleep: assert property (p_sleep) else $error("standby entry wrong");
  property p_wdt; $rose(wdt_clear_o) |->
    $past(instr_i) == `WORD_SLEEP || $past(instr_i) == `WORD_WDT_CLEAR; endproperty
  a_wdt: assert property (p_wdt) else $error("stray watchdog clear");
  property p_wake; sleep_o && wake_i |=> !sleep_o; endproperty
  a_wake: assert property (p_wake) else $error("wake ignored");
  property p_gie; $rose(gie_o) |-> $past(instr_i) == `WORD_INT_RETURN ||
    $past(wb_we_i && wb_stb_i); endproperty
  a_gie: assert property (p_gie) else $error("stray interrupt enable");
endmodule
bind fourteen_bit_instruction_decoder decoder_checker chk_u (.*);
`default_nettype wire

// [prog_mem_model.sv]
// Program memory and file register model on the decoder's far side.
`default_nettype none
module prog_mem_model (
  // Clock.
  input  wire logic        clk_i,
  // Instruction fetch.
  input  wire logic [12:0] pc_i,
  output wire logic [13:0] instr_o,
  // File register access.
  input  wire logic [6:0]  file_addr_i,
  output wire logic [7:0]  file_rdata_o,
  input  wire logic        file_we_i,
  input  wire logic [7:0]  file_wdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [13:0] rom [0:31];  // Program words, loaded by the bench.
  logic [7:0]  ram [0:127]; // File registers.
  // Combinational fetch; a no-op word past the 32-word array.
  assign instr_o = (pc_i < 13'h0020) ? rom[pc_i[4:0]] : 14'h0000;
  assign file_rdata_o = ram[file_addr_i];
  // File writes land at the rising edge.
  always @(posedge clk_i) begin
    if (file_we_i) begin
      ram[file_addr_i] <= file_wdata_i;
    end
  end
endmodule
`default_nettype wire

// [fourteen_bit_instruction_decoder_test.sv]
// Self-checking bench for the instruction decoder.
`default_nettype none
`include "decoder_defines.vh"
module fourteen_bit_instruction_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, port_pins_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic        wb_ack_o, file_we_o, prescaler_clear_o, sleep_o, wdt_clear_o, gie_o;
  logic        prescaler_to_timer_i = 1'b0, wake_i = 1'b0;
  logic [12:0] pc_o;
  logic [13:0] instr_i;
  logic [6:0]  file_addr_o;
  logic [7:0]  file_rdata_i, file_wdata_o;
  int          fails = 0, checked = 0, cyc_cnt = 0;
  fourteen_bit_instruction_decoder dut_u (.*);
  prog_mem_model pm_u (.clk_i, .pc_i(pc_o), .instr_o(instr_i), .file_addr_i(file_addr_o),
    .file_rdata_o(file_rdata_i), .file_we_i(file_we_o), .file_wdata_i(file_wdata_o));
  ////////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock and a cycle ceiling against hangs.
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 30000) begin
      fails++;
      stop_test();
    end
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Compares one value and reports a mismatch.
  task automatic check(input string what, input logic [31:0] exp, act);
    checked++;
    if (exp !== act) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, act);
    end
  endtask
  // One classic Wishbone cycle, begun right after a rising edge.
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd);
    int n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    if (n >= 20) fails++;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    @(posedge clk_i);
  endtask
  // Loads a program under reset, then runs to the end address.
  task automatic run(input logic [13:0] w [6], input logic [12:0] stop);
    int n = 0;
    rst_i <= 1'b1;
    @(posedge clk_i);
    foreach (w[i]) pm_u.rom[i] = w[i];
    pm_u.ram[8'h22] = 8'h5a;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pc_o !== stop && n < 40);
    if (n >= 40) fails++;
    @(posedge clk_i);
  endtask
  // Reference: {skip, file write, flags z dc c, result} for one word.
  function automatic logic [12:0] model(input logic [13:0] ins, input logic [7:0] w, fv);
    logic [7:0] op, r;
    logic [4:0] h;
    logic       c, dc, z, sk, wr, lit;
    lit = ins[13:12] == 2'b11;
    op  = lit ? ins[7:0] : fv;
    {c, dc, z, sk} = 4'h0;
    wr  = !lit && ins[7];
    r   = op;
    if (ins[13:12] == 2'b01) begin
      r  = ins[10] ? (fv | (8'h01 << ins[9:7])) : (fv & ~(8'h01 << ins[9:7]));
      wr = !ins[11];
      sk = ins[11] && fv[ins[9:7]] == ins[10];
      return {sk, wr, 3'b000, r};
    end
    case ({lit, ins[11:8]})
      5'h04, 5'h18: r = w | op;
      5'h05, 5'h19: r = w & op;
      5'h06, 5'h1a: r = w ^ op;
      5'h07, 5'h1e: begin
        {c, r} = {1'b0, w} + {1'b0, op};
        h = {1'b0, w[3:0]} + {1'b0, op[3:0]};
        dc = h[4];
      end
      5'h02, 5'h1c: begin
        {c, r} = {1'b0, op} - {1'b0, w};
        c = !c;
        dc = op[3:0] >= w[3:0];
      end
      5'h0d: {c, r} = {op, 1'b0};
      5'h0c: {r, c} = {1'b0, op};
      5'h0b: r = op - 8'h01;
      5'h0f: r = op + 8'h01;
      default: r = op;
    endcase
    if (ins[11:8] inside {4'hb, 4'hf} && !lit) sk = r == 8'h00;
    if (lit ? ins[11] : ins[11:8] inside {4'h2, [4'h4:4'h7]}) z = r == 8'h00;
    return {sk, wr, z, dc, c, r};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Random words with corners, then calls, standby and bus.
  initial begin
    logic [5:0]  ops [19] = '{6'h38, 6'h39, 6'h3a, 6'h3e, 6'h3c, 6'h30, 6'h04, 6'h05, 6'h06,
                              6'h07, 6'h02, 6'h0d, 6'h0c, 6'h0b, 6'h0f, 6'h10, 6'h14, 6'h18, 6'h1c};
    logic [6:0]  fs [3] = '{7'h20, `PORT_ADDR, `TIMER_ADDR};
    logic [13:0] ins, rw;
    logic [12:0] e;
    logic [31:0] r, rd;
    logic [7:0]  v, b, acc;
    logic [6:0]  f;
    void'($urandom(32'h8737));
    for (int i = 0; i < 95; i++) begin
      r = $urandom;
      v = (i < 19) ? 8'h01 : (i < 38) ? 8'hff : r[31:24];
      b = (i < 38) ? 8'h01 : r[23:16];
      f = fs[r[12:11]%3];
      ins = (ops[i%19][5:4] == 2'b11) ? {ops[i%19], r[7:0]} :
            (ops[i%19][5:4] == 2'b00) ? {ops[i%19], r[7], f} : {ops[i%19][5:2], r[9:7], f};
      port_pins_i <= r[15:8];
      prescaler_to_timer_i <= r[10];
      run('{14'h3000 | v, 14'h0080 | f, 14'h3000 | b, ins, 14'h00a2, 14'h2805}, 13'h0005);
      e = model(ins, b, (f == `PORT_ADDR) ? r[15:8] : v);
      acc = (ins[13:12] == 2'b11 || (ins[13:12] == 2'b00 && !ins[7])) ? e[7:0] : b;
      wb_xfer(1'b0, `REG_ACC, 32'h0, rd);
      check("acc", acc, rd);
      wb_xfer(1'b0, `REG_STATUS, 32'h0, rd);
      check("flags", {2'b11, e[10:8]}, rd[4:0]);
      check("file", e[11] ? e[7:0] : v, pm_u.ram[f]);
      check("skip", e[12] ? 8'h5a : acc, pm_u.ram[8'h22]);
    end
    for (int i = 0; i < 6; i++) begin
      r = $urandom;
      rw = (i % 3 == 0) ? `WORD_RETURN : (i % 3 == 1) ? `WORD_INT_RETURN : 14'h3400 | r[15:8];
      run('{14'h2004, 14'h00a2, 14'h2802, 14'h0000, 14'h3000 | r[7:0], rw}, 13'h0002);
      check("ret", (i % 3 == 2) ? r[15:8] : r[7:0], pm_u.ram[8'h22]);
      check("gie", i % 3 == 1, gie_o);
    end
    run('{`WORD_SLEEP, `WORD_WDT_CLEAR, 14'h2802, 14'h0, 14'h0, 14'h0}, 13'h0001);
    wb_xfer(1'b0, `REG_STATUS, 32'h0, rd);
    check("standby", 3'h6, rd[5:3]);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb_xfer(1'b0, `REG_STATUS, 32'h0, rd);
    check("awake", 3'h3, rd[5:3]);
    wb_xfer(1'b1, 8'h10, 32'hffff_ffff, rd);
    wb_xfer(1'b0, 8'h10, 32'h0, rd);
    check("unmapped", 32'h0, rd);
    wb_xfer(1'b1, `REG_CTRL, 32'h3, rd);
    check("ctrl gie", 1'b1, gie_o);
    stop_test();
  end
endmodule
`default_nettype wire
